// ===== hw/sbap_defines.svh
`ifndef SBAP_DEFINES_SVH
`define SBAP_DEFINES_SVH
`define SBAP_ADDR_W 32
`define SBAP_TT_W 5
`define SBAP_TT_RW_BIT 1
`define SBAP_TSZ_W 4
`define SBAP_CS_N 8
`define SBAP_BADDR_W 5
`define SBAP_BURST_BEATS 8
`define SBAP_IRQ_N 15
`define SBAP_SNOOP_ADDR 32'h0000_0000
`define SBAP_SNOOP_MASK 32'h0000_0000
`define SBAP_SLAVE_BASE 32'hf000_0000
`define SBAP_SLAVE_MASK 32'hf000_0000
`endif

// ===== hw/sbap_pkg.sv
package sbap_pkg;
  typedef enum logic [1:0] {
    SBAP_IDLE = 2'b00,
    SBAP_OWN = 2'b01,
    SBAP_SNOOP = 2'b11
  } sbap_state_t;
  typedef enum logic {
    SBAP_MODE_INT = 1'b0,
    SBAP_MODE_EXT = 1'b1
  } sbap_mode_t;
endpackage : sbap_pkg

// ===== hw/sbap_sync.sv
`timescale 1ns/1ps
`include "sbap_defines.svh"
module sbap_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // raw and synchronised
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  // first stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end
  assign q_o = sync_q;
endmodule : sbap_sync

// ===== hw/sbap_addr_phase.sv
// Operation
// R1 - external-master mode: 32 address pins are shared, two-way system address bus.
// R2 - external mode: drive own masters' addresses, decode outside masters' addresses.
// R3 - internal-master mode: address pins driven only by memory controller.
// R4 - bus owner drives five transfer-type lines for whole address tenure.
// R5 - simple systems may use only type line one as read/write.
// R6 - bus owner drives four transfer-size lines with byte count.
// R7 - owner asserts burst flag for bursts; a burst is eight words.
// R8 - device drives global snoop when its own master starts a transaction; code asserts it only in external mode with mst_global_i set.
// R9 - eight chip-select outputs, each enabling one memory or peripheral.
// R10 - five burst-address outputs increment within bursts.
// R11 - fifteen interrupt request inputs forwarded to internal interrupt controller.
// R12 - owner holds address and attributes stable until tenure ends.
`timescale 1ns/1ps
`include "sbap_defines.svh"
module sbap_addr_phase
  import sbap_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // configuration
  input wire logic ext_mode_i,
  input wire logic simple_rw_i,
  // tenure control from arbitration logic
  input wire logic tenure_start_i,
  input wire logic tenure_end_i,
  input wire logic ext_start_i,
  // internal master request
  input wire logic [`SBAP_ADDR_W-1:0] mst_addr_i,
  input wire logic [`SBAP_TT_W-1:0] mst_xfer_type_i,
  input wire logic mst_rw_i,
  input wire logic [`SBAP_TSZ_W-1:0] mst_xfer_size_i,
  input wire logic mst_burst_i,
  input wire logic mst_global_i,
  // memory controller
  input wire logic [`SBAP_ADDR_W-1:0] mc_addr_i,
  input wire logic [`SBAP_CS_N-1:0] mc_cs_i,
  input wire logic mc_beat_i,
  // address pins
  input wire logic [`SBAP_ADDR_W-1:0] addr_i,
  output logic [`SBAP_ADDR_W-1:0] addr_o,
  output logic addr_oe_o,
  // attribute pins
  input wire logic xfer_type_b0_i,
  input wire logic xfer_type_rw_i,
  input wire logic [2:0] xfer_type_hi_i,
  output logic xfer_type_b0_o,
  output logic xfer_type_rw_o,
  output logic [2:0] xfer_type_hi_o,
  input wire logic [`SBAP_TSZ_W-1:0] xfer_size_i,
  output logic [`SBAP_TSZ_W-1:0] xfer_size_o,
  input wire logic burst_flag_i,
  output logic burst_flag_o,
  output logic attr_oe_o,
  output logic global_snoop_o,
  // memory side
  output logic [`SBAP_CS_N-1:0] chip_sel_o,
  output logic [`SBAP_BADDR_W-1:0] burst_addr_out_o,
  // interrupts
  input wire logic [`SBAP_IRQ_N-1:0] ext_int_req_i,
  output logic [`SBAP_IRQ_N-1:0] int_req_o,
  // outside master decode results
  output logic slave_hit_o,
  output logic snoop_req_o,
  output logic [`SBAP_ADDR_W-1:0] ext_addr_o,
  output logic [`SBAP_TT_W-1:0] ext_xfer_type_o,
  output logic [`SBAP_TSZ_W-1:0] ext_xfer_size_o,
  output logic ext_burst_o,
  output logic busy_o
);
  sbap_state_t state_q;
  logic [`SBAP_ADDR_W-1:0] addr_q;
  logic [`SBAP_TT_W-1:0] tt_q;
  logic [`SBAP_TSZ_W-1:0] tsz_q;
  logic burst_q;
  logic global_q;
  logic [`SBAP_CS_N-1:0] cs_q;
  logic [`SBAP_BADDR_W-1:0] baddr_q;
  logic [2:0] beat_q;
  logic [`SBAP_ADDR_W-1:0] ext_addr_q;
  logic [`SBAP_TT_W-1:0] ext_tt_q;
  logic [`SBAP_TSZ_W-1:0] ext_tsz_q;
  logic ext_burst_q;
  logic slave_hit_q;
  logic snoop_q;
  logic [`SBAP_ADDR_W+`SBAP_TT_W+`SBAP_TSZ_W:0] pin_raw;
  logic [`SBAP_ADDR_W+`SBAP_TT_W+`SBAP_TSZ_W:0] pin_s;
  logic [`SBAP_ADDR_W-1:0] pin_addr;
  logic [`SBAP_TT_W-1:0] pin_tt;
  logic [`SBAP_TSZ_W-1:0] pin_tsz;
  logic pin_burst;
  logic ext_start_s;
  logic own;
  // qualifies a request taken this edge; read by the checks only
  logic own_take;

  function automatic logic addr_match(input logic [`SBAP_ADDR_W-1:0] a,
                                      input logic [`SBAP_ADDR_W-1:0] base,
                                      input logic [`SBAP_ADDR_W-1:0] mask);
    addr_match = ((a ^ base) & mask) == '0;
  endfunction : addr_match

  // pins from other masters pass two flops before decode
  assign pin_raw = {addr_i, xfer_type_hi_i, xfer_type_rw_i, xfer_type_b0_i, xfer_size_i, burst_flag_i};
  sbap_sync #(.W(`SBAP_ADDR_W + `SBAP_TT_W + `SBAP_TSZ_W + 1)) u_pin_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .d_i(pin_raw),
    .q_o(pin_s)
  );
  sbap_sync #(.W(`SBAP_IRQ_N)) u_irq_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .d_i(ext_int_req_i),
    .q_o(int_req_o) // R11
  );
  sbap_sync #(.W(1)) u_ts_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .d_i(ext_start_i),
    .q_o(ext_start_s)
  );
  assign {pin_addr, pin_tt, pin_tsz, pin_burst} = pin_s;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q <= SBAP_IDLE;
    end else begin
      unique case (state_q)
        SBAP_IDLE: begin
          if (tenure_start_i) begin
            state_q <= SBAP_OWN;
          end else if (ext_mode_i && ext_start_s) begin
            state_q <= SBAP_SNOOP;
          end
        end
        SBAP_OWN: begin
          if (tenure_end_i) begin
            state_q <= SBAP_IDLE;
          end
        end
        SBAP_SNOOP: begin
          state_q <= SBAP_IDLE;
        end
        default: begin
          state_q <= SBAP_IDLE;
        end
      endcase
    end
  end
  assign own = state_q == SBAP_OWN;
  assign own_take = state_q == SBAP_IDLE && tenure_start_i;

  // attributes latched once per tenure, held to its end
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      addr_q <= '0;
      tt_q <= '0;
      tsz_q <= '0;
      burst_q <= 1'b0;
      global_q <= 1'b0;
    end else if (state_q == SBAP_IDLE && tenure_start_i) begin // R12
      addr_q <= ext_mode_i ? mst_addr_i : mc_addr_i; // R2 R3
      if (simple_rw_i) begin
        tt_q <= '0;
        tt_q[`SBAP_TT_RW_BIT] <= mst_rw_i; // R5
      end else begin
        tt_q <= mst_xfer_type_i; // R4
      end
      tsz_q <= mst_xfer_size_i; // R6
      burst_q <= mst_burst_i; // R7
      global_q <= ext_mode_i & mst_global_i; // R8
    end
  end

  // burst counter stops at seven and holds there until the next tenure
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      beat_q <= '0;
      baddr_q <= '0;
    end else if (state_q == SBAP_IDLE && tenure_start_i) begin
      beat_q <= '0;
      baddr_q <= ext_mode_i ? mst_addr_i[`SBAP_BADDR_W-1:0] : mc_addr_i[`SBAP_BADDR_W-1:0];
    end else if (burst_q && mc_beat_i && beat_q != 3'(`SBAP_BURST_BEATS - 1)) begin
      beat_q <= beat_q + 3'h1;
      baddr_q <= baddr_q + 5'h4; // R10
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cs_q <= '0;
    end else begin
      cs_q <= mc_cs_i; // R9
    end
  end

  // outside master tenure decode
  // start and data share one two-flop delay; relies on the master holding data
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ext_addr_q <= '0;
      ext_tt_q <= '0;
      ext_tsz_q <= '0;
      ext_burst_q <= 1'b0;
      slave_hit_q <= 1'b0;
      snoop_q <= 1'b0;
    end else if (state_q == SBAP_IDLE && !tenure_start_i && ext_mode_i && ext_start_s) begin
      ext_addr_q <= pin_addr;
      ext_tt_q <= pin_tt;
      ext_tsz_q <= pin_tsz;
      ext_burst_q <= pin_burst;
      slave_hit_q <= addr_match(pin_addr, `SBAP_SLAVE_BASE, `SBAP_SLAVE_MASK); // R2
      snoop_q <= addr_match(pin_addr, `SBAP_SNOOP_ADDR, `SBAP_SNOOP_MASK);
    end else begin
      slave_hit_q <= 1'b0;
      snoop_q <= 1'b0;
    end
  end

  // pins driven only while tenure is ours; in internal mode address always driven
  assign addr_oe_o = ext_mode_i ? own : 1'b1; // R1 R3
  assign addr_o = own ? addr_q : (ext_mode_i ? '0 : mc_addr_i);
  assign attr_oe_o = own; // R4 R6 R7
  assign xfer_type_b0_o = tt_q[0];
  assign xfer_type_rw_o = tt_q[`SBAP_TT_RW_BIT];
  assign xfer_type_hi_o = tt_q[4:2];
  assign xfer_size_o = tsz_q;
  assign burst_flag_o = burst_q;
  assign global_snoop_o = own & global_q; // R8
  assign chip_sel_o = cs_q;
  assign burst_addr_out_o = baddr_q;
  assign slave_hit_o = slave_hit_q;
  assign snoop_req_o = snoop_q;
  assign ext_addr_o = ext_addr_q;
  assign ext_xfer_type_o = ext_tt_q;
  assign ext_xfer_size_o = ext_tsz_q;
  assign ext_burst_o = ext_burst_q;
  assign busy_o = state_q != SBAP_IDLE;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  addr_hold_a: assert property (own && !$rose(own) |-> $stable(addr_o) && $stable(xfer_size_o)) // R12
    else $error("address moved during tenure");
  attr_drive_a: assert property (own_take |=> attr_oe_o && addr_oe_o) // R4 R1
    else $error("attributes not driven by owner");
  int_mode_a: assert property (!ext_mode_i && !own |-> addr_oe_o && addr_o == mc_addr_i) // R3
    else $error("memory controller not on address");
  ext_release_a: assert property (ext_mode_i && !own |-> !addr_oe_o) // R1
    else $error("address driven while not owner");
  global_own_a: assert property (global_snoop_o |-> own && ext_mode_i) // R8
    else $error("global asserted outside own tenure");
  rw_simple_a: assert property ($rose(own) && $past(simple_rw_i) |-> xfer_type_rw_o == $past(mst_rw_i)
    && !xfer_type_b0_o && xfer_type_hi_o == 3'h0) // R5
    else $error("simple read/write encoding wrong");
  burst_step_a: assert property (burst_q && mc_beat_i && beat_q != 3'h7 && !(state_q == SBAP_IDLE && tenure_start_i)
    |=> burst_addr_out_o == $past(baddr_q) + 5'h4) // R10
    else $error("burst address did not step");
  burst_len_a: assert property (beat_q == 3'h7 && !(state_q == SBAP_IDLE && tenure_start_i) |=> beat_q == 3'h7) // R7
    else $error("burst exceeded eight beats");
  cs_follow_a: assert property (##1 chip_sel_o == $past(mc_cs_i)) // R9
    else $error("chip select lags");
  irq_delay_a: assert property (##2 int_req_o == $past(ext_int_req_i, 2)) // R11
    else $error("interrupt not forwarded");
  snoop_one_a: assert property (state_q == SBAP_SNOOP |=> state_q == SBAP_IDLE) // R2
    else $error("snoop state stuck");

  // take, hold and drop of our own tenure
  own_hold_a: assert property (own && !tenure_end_i |=> own) // R4
    else $error("tenure dropped early");
  own_end_a: assert property (own && tenure_end_i |=> !attr_oe_o && !global_snoop_o) // R4
    else $error("pins driven after tenure end");
  type_latch_a: assert property (own_take && !simple_rw_i |=> {xfer_type_hi_o, xfer_type_rw_o, xfer_type_b0_o}
    == $past(mst_xfer_type_i)) // R4
    else $error("transfer type not latched");
  size_latch_a: assert property (own_take |=> xfer_size_o == $past(mst_xfer_size_i)
    && burst_flag_o == $past(mst_burst_i)) // R6 R7
    else $error("size or burst not latched");
  int_addr_a: assert property (own_take && !ext_mode_i |=> addr_o == $past(mc_addr_i)) // R3
    else $error("own address not from memory controller");
  ext_addr_a: assert property (own_take && ext_mode_i |=> addr_o == $past(mst_addr_i)) // R2
    else $error("own address not from internal master");
  attr_steady_a: assert property (own && !$rose(own) |-> $stable(burst_flag_o) && $stable(xfer_type_hi_o)
    && $stable(global_snoop_o)) // R12
    else $error("attributes moved during tenure");
  burst_start_a: assert property (own_take |=> beat_q == 3'h0
    && burst_addr_out_o == addr_o[`SBAP_BADDR_W-1:0]) // R10
    else $error("burst address not seeded");
  // outside master capture
  snoop_capture_a: assert property (state_q == SBAP_SNOOP |-> ext_addr_o == $past(pin_addr)
    && ext_xfer_size_o == $past(pin_tsz)) // R2
    else $error("outside address not captured");
  int_quiet_a: assert property ($past(!ext_mode_i) |-> !snoop_req_o && !slave_hit_o) // R2
    else $error("decode in internal mode");
  ext_keep_a: assert property (!ext_start_s |=> $stable(ext_addr_o)) // R2
    else $error("captured address moved");

  own_tenure_c: cover property ($rose(own) ##[1:8] $fell(own));
  ext_tenure_c: cover property (state_q == SBAP_SNOOP && slave_hit_q);
  burst_full_c: cover property (beat_q == 3'h7);
  global_c: cover property (global_snoop_o);
  ext_miss_c: cover property (state_q == SBAP_SNOOP && !slave_hit_q);
endmodule : sbap_addr_phase

// ===== bench/sbap_ext_master.sv
`timescale 1ns/1ps
module sbap_ext_master (
  // clock
  input wire logic clk_i,
  // pins toward the device
  output logic [31:0] addr_o,
  output logic [4:0] type_o,
  output logic [3:0] size_o,
  output logic burst_o,
  output logic start_o
);
  logic [31:0] last_q;
  logic drive_q;
  // released lines show the inverse so a stale address never matches
  assign addr_o = drive_q ? last_q : ~last_q;
  initial begin
    {drive_q, last_q, type_o, size_o, burst_o, start_o} = '0;
  end
  task automatic drive(input logic [31:0] a, input logic [4:0] t, input logic [3:0] s, input logic b);
    @(posedge clk_i);
    drive_q <= 1'b1;
    last_q <= a;
    type_o <= t;
    size_o <= s;
    burst_o <= b;
    start_o <= 1'b1;
    @(posedge clk_i);
    start_o <= 1'b0;
  endtask : drive
  task automatic release_bus();
    @(posedge clk_i);
    drive_q <= 1'b0;
    type_o <= ~type_o;
    size_o <= ~size_o;
    burst_o <= ~burst_o;
  endtask : release_bus
endmodule : sbap_ext_master

// ===== bench/test_system_bus_address_phase.sv
`timescale 1ns/1ps
module test_system_bus_address_phase;
  import sbap_pkg::*;
  logic clk_i, reset_i, ext_mode_i, simple_rw_i, tenure_start_i, tenure_end_i, mc_beat_i;
  logic mst_rw_i, mst_burst_i, mst_global_i, addr_oe_o, attr_oe_o, xfer_type_b0_o, xfer_type_rw_o;
  logic burst_flag_o, global_snoop_o, slave_hit_o, snoop_req_o, ext_burst_o, busy_o, em_burst, em_start;
  logic [31:0] mst_addr_i, mc_addr_i, addr_o, ext_addr_o, em_addr;
  logic [4:0] mst_xfer_type_i, ext_xfer_type_o, em_type, burst_addr_out_o;
  logic [3:0] mst_xfer_size_i, xfer_size_o, ext_xfer_size_o, em_size;
  logic [7:0] mc_cs_i, chip_sel_o, cs, cs_p;
  logic [14:0] ext_int_req_i, int_req_o, irq, irq_p, irq_pp;
  logic [2:0] xfer_type_hi_o;
  integer seed, fails, comparisons, cycles;
  sbap_ext_master i_em (.clk_i(clk_i), .addr_o(em_addr), .type_o(em_type), .size_o(em_size),
    .burst_o(em_burst), .start_o(em_start));
  // pin levels resolved from the device's enables alone
  sbap_addr_phase i_dut (.clk_i(clk_i), .reset_i(reset_i), .ext_mode_i(ext_mode_i), .simple_rw_i(simple_rw_i),
    .tenure_start_i(tenure_start_i), .tenure_end_i(tenure_end_i), .ext_start_i(em_start),
    .mst_addr_i(mst_addr_i), .mst_xfer_type_i(mst_xfer_type_i), .mst_rw_i(mst_rw_i),
    .mst_xfer_size_i(mst_xfer_size_i), .mst_burst_i(mst_burst_i), .mst_global_i(mst_global_i),
    .mc_addr_i(mc_addr_i), .mc_cs_i(mc_cs_i), .mc_beat_i(mc_beat_i),
    .addr_i(addr_oe_o ? addr_o : em_addr), .addr_o(addr_o), .addr_oe_o(addr_oe_o),
    .xfer_type_b0_i(attr_oe_o ? xfer_type_b0_o : em_type[0]),
    .xfer_type_rw_i(attr_oe_o ? xfer_type_rw_o : em_type[1]),
    .xfer_type_hi_i(attr_oe_o ? xfer_type_hi_o : em_type[4:2]), .xfer_type_b0_o(xfer_type_b0_o),
    .xfer_type_rw_o(xfer_type_rw_o), .xfer_type_hi_o(xfer_type_hi_o),
    .xfer_size_i(attr_oe_o ? xfer_size_o : em_size), .xfer_size_o(xfer_size_o),
    .burst_flag_i(attr_oe_o ? burst_flag_o : em_burst), .burst_flag_o(burst_flag_o), .attr_oe_o(attr_oe_o),
    .global_snoop_o(global_snoop_o), .chip_sel_o(chip_sel_o), .burst_addr_out_o(burst_addr_out_o),
    .ext_int_req_i(ext_int_req_i), .int_req_o(int_req_o), .slave_hit_o(slave_hit_o),
    .snoop_req_o(snoop_req_o), .ext_addr_o(ext_addr_o), .ext_xfer_type_o(ext_xfer_type_o),
    .ext_xfer_size_o(ext_xfer_size_o), .ext_burst_o(ext_burst_o), .busy_o(busy_o));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  always @(posedge clk_i) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      fails = fails + 1;
      give_verdict();
    end
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  function automatic logic [4:0] exp_baddr(input logic [4:0] base, input int k);
    exp_baddr = base + 5'(4 * (k > 7 ? 7 : k));
  endfunction : exp_baddr
  function automatic logic exp_hit(input logic [31:0] a);
    exp_hit = a[31:28] == 4'hf;
  endfunction : exp_hit
  task automatic own_tenure(input int beats);
    logic [31:0] a, m, ea;
    logic [4:0] t;
    logic [3:0] s;
    logic b, g, r;
    a = $random(seed);
    m = $random(seed);
    t = 5'($random(seed));
    s = 4'($random(seed));
    {b, g, r} = 3'($random(seed));
    if (beats > 0) b = 1'b1;
    @(posedge clk_i);
    // mode has settled here; own address comes from the master or the memory controller
    ea = ext_mode_i ? a : m;
    {mst_addr_i, mst_xfer_type_i, mst_xfer_size_i, mst_burst_i, mst_global_i, mst_rw_i} <= {a, t, s, b, g, r};
    mc_addr_i <= m;
    tenure_start_i <= 1'b1;
    @(posedge clk_i);
    tenure_start_i <= 1'b0;
    // inputs move on at once; the pins must keep the latched request
    {mst_addr_i, mst_xfer_type_i, mst_xfer_size_i, mc_addr_i} <= ~{a, t, s, m};
    for (int k = 0; k <= beats; k++) begin
      if (k > 0) begin
        @(posedge clk_i);
        mc_beat_i <= 1'b1;
        @(posedge clk_i);
        mc_beat_i <= 1'b0;
      end
      #1;
      chk("oe", {addr_oe_o, attr_oe_o}, 2'b11);
      chk("addr", addr_o, ea);
      chk("busy", busy_o, 1'b1);
      chk("rw", xfer_type_rw_o, simple_rw_i ? r : t[1]);
      if (!simple_rw_i) chk("type", {xfer_type_hi_o, xfer_type_rw_o, xfer_type_b0_o}, t);
      else chk("type_simple", {xfer_type_hi_o, xfer_type_b0_o}, 4'h0);
      chk("size_burst", {xfer_size_o, burst_flag_o}, {s, b});
      chk("global", global_snoop_o, g & ext_mode_i);
      if (b) chk("baddr", burst_addr_out_o, exp_baddr(ea[4:0], k));
    end
    @(posedge clk_i);
    tenure_end_i <= 1'b1;
    @(posedge clk_i);
    tenure_end_i <= 1'b0;
    mc_addr_i <= $random(seed);
    #1;
    chk("oe_end", addr_oe_o, !ext_mode_i);
    chk("busy_end", busy_o, 1'b0);
    if (!ext_mode_i) chk("addr_mc", addr_o, mc_addr_i);
    @(posedge clk_i);
  endtask : own_tenure
  task automatic outside(input logic [31:0] a);
    logic [4:0] t;
    logic [3:0] s;
    logic b, seen;
    {t, s, b} = 10'($random(seed));
    seen = 1'b0;
    i_em.drive(a, t, s, b);
    for (int k = 0; k < 6 && !seen; k++) begin
      @(posedge clk_i);
      #1;
      if (snoop_req_o === 1'b1) begin
        seen = 1'b1;
        chk("slave_hit", slave_hit_o, exp_hit(a));
      end
    end
    chk("snoop_seen", seen, 1'b1);
    chk("ext_addr", ext_addr_o, a);
    chk("ext_attr", {ext_xfer_type_o, ext_xfer_size_o, ext_burst_o}, {t, s, b});
    chk("no_drive", addr_oe_o, 1'b0);
    i_em.release_bus();
    repeat (3) @(posedge clk_i);
  endtask : outside
  initial begin
    {ext_mode_i, simple_rw_i, tenure_start_i, tenure_end_i, mc_beat_i, mst_rw_i, mst_burst_i} = '0;
    {mst_global_i, mst_addr_i, mc_addr_i, mst_xfer_type_i, mst_xfer_size_i, mc_cs_i, ext_int_req_i} = '0;
    {fails, comparisons, cycles} = '0;
    seed = 32'hd1f4;
    reset_i = 1'b1;
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      @(posedge clk_i);
      cs = 8'($random(seed));
      irq = 15'($random(seed));
      mc_cs_i <= cs;
      ext_int_req_i <= irq;
      mc_addr_i <= $random(seed);
      #1;
      if (i > 0) chk("chip_sel", chip_sel_o, cs_p);
      if (i > 1) chk("int_req", int_req_o, irq_pp);
      chk("addr_mc", addr_o, mc_addr_i);
      irq_pp = irq_p;
      irq_p = irq;
      cs_p = cs;
    end
    own_tenure(0);
    own_tenure(9);
    @(posedge clk_i);
    ext_mode_i <= 1'b1;
    own_tenure(9);
    own_tenure(0);
    simple_rw_i <= 1'b1;
    own_tenure(0);
    simple_rw_i <= 1'b0;
    outside(32'hf123_4560);
    outside(32'h1000_0040);
    give_verdict();
  end
endmodule : test_system_bus_address_phase
